// file: verilog/urx_pkg.sv
// package for the serial receive configuration and status block
`default_nettype none
package urx_pkg;
  // register byte addresses on the apb bus
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  // mode register fields
  localparam int MODE_INV_BIT = 4;
  localparam int MODE_HS_BIT = 3;
  localparam int MODE_FMT_LSB = 1;
  localparam int MODE_STOP_BIT = 0;
  // status register fields
  localparam int STA_ADDRESS_DETECT_ENABLE_BIT = 5;
  localparam int STA_IDLE_BIT = 4;
  localparam int STA_PARITY_ERROR_FLAG_BIT = 3;
  localparam int STA_FRAMING_ERROR_FLAG_BIT = 2;
  localparam int STA_OVERRUN_ERROR_FLAG_BIT = 1;
  localparam int STA_AVAIL_BIT = 0;
  // interrupt status bits
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam int IRQ_OVR_BIT = 2;
  localparam int IRQ_W = 3;
  // frame format codes
  localparam logic [1:0] FMT_9N = 2'h3;
  localparam logic [1:0] FMT_8O = 2'h2;
  localparam logic [1:0] FMT_8E = 2'h1;
  localparam logic [1:0] FMT_8N = 2'h0;
  // oversampling ratios
  localparam logic [4:0] OVS_HS = 5'h04;
  localparam logic [4:0] OVS_STD = 5'h10;
  // reset values
  localparam logic [15:0] BAUD_RST = 16'h0000;
  localparam logic [15:0] MODE_RST = 16'h0000;
  // receiver states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_START = 5'h02,
    ST_DATA = 5'h04,
    ST_PAR = 5'h08,
    ST_STOP = 5'h10
  } urx_state_t;
  // one received character with its error flags
  typedef struct packed {
    logic parity_error_flag;
    logic framing_error_flag;
    logic [8:0] data;
  } urx_char_t;
endpackage : urx_pkg
`default_nettype wire

// file: verilog/urx_top.sv
// serial receiver with mode and status registers on apb
`default_nettype none
// Behaviour
// - invert bit makes idle level low
// - high speed gives 4, else 16 samples
// - format field picks width and parity
// - stop select gives one or two stops
// - address mode keeps ninth-bit-set characters
// - idle flag high while receiver idle
// - parity flag for top buffered character
// - framing flag for top buffered character
// - overrun set on overflow, software clears
// - overrun clear empties buffer and shifter
// - data available while buffer not empty
module urx_top import urx_pkg::*; #(
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RSTN_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // serial line and interrupt
  input wire logic RX_I,
  output logic IRQ_O
);
  localparam int PW = $clog2(DEPTH);
  // pointers wrap on their own width, so DEPTH is meant to be a power of two;
  // any other depth would need explicit wrap logic on both pointers

  // synchroniser, three stages
  logic [2:0] sync_ff;
  logic rx_ff; // filtered line
  // configuration
  logic [15:0] mode_ff;
  logic [15:0] baud_ff;
  logic addren_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic overrun_error_flag_ff;
  logic pop_ok_ff; // setup phase saw a character to hand out
  // receive buffer
  urx_char_t buf_ff [DEPTH];
  logic [PW-1:0] wptr_ff;
  logic [PW-1:0] rptr_ff;
  logic [PW:0] cnt_ff;
  // receiver
  urx_state_t state_ff;
  logic [15:0] bdiv_ff; // baud divider
  logic [4:0] tick_ff; // oversample count in a bit
  logic [3:0] bit_ff; // bit index
  logic [8:0] shift_ff;
  logic par_ff;
  logic stop2_ff; // second stop pending
  logic done_ff; // a character completed this cycle
  urx_char_t char_ff;

  // bus decode; the answer is a single access cycle, so writes and pops act
  // on the access edge while read data was already captured at setup
  wire acc = PSEL_I && PENABLE_I;
  wire wr = acc && PWRITE_I;
  wire rd = acc && !PWRITE_I;
  wire rd_data = rd && PADDR_I == ADDR_DATA;
  wire rd_irq = rd && PADDR_I == ADDR_IRQ_STAT;
  // overrun clear: software writes the bit 1 to 0
  wire overrun_error_flag_clr = wr && PADDR_I == ADDR_STAT && overrun_error_flag_ff && !PWDATA_I[STA_OVERRUN_ERROR_FLAG_BIT];

  // decoded configuration
  // the frame shape is read live from the mode register, so software
  // should only change it while the receiver is idle
  wire idle_lvl = !mode_ff[MODE_INV_BIT];
  wire [1:0] fmt = mode_ff[MODE_FMT_LSB +: 2];
  wire nine = fmt == FMT_9N;
  wire has_par = fmt == FMT_8O || fmt == FMT_8E;
  wire [4:0] ovs = mode_ff[MODE_HS_BIT] ? OVS_HS : OVS_STD;
  wire [4:0] mid = {1'b0, ovs[4:1]};
  wire baud_tick = bdiv_ff == baud_ff;
  wire bit_end = baud_tick && tick_ff == ovs - 5'h01;
  wire mid_pt = baud_tick && tick_ff == mid;
  wire line = rx_ff ^ !idle_lvl; // line in idle-high sense
  wire full = cnt_ff == (PW+1)'(DEPTH);
  wire empty = cnt_ff == '0;

  // input synchroniser; change taken when stages two and three agree
  // the filtered line only moves once two stages agree, so a single-cycle
  // spike that is caught by one stage never reaches the receiver
  // reset loads the idle-high level so no false start follows reset
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      sync_ff <= 3'h7;
      rx_ff <= 1'b1;
    end else begin
      sync_ff <= {sync_ff[1:0], RX_I};
      if (sync_ff[2] == sync_ff[1]) begin
        rx_ff <= sync_ff[2];
      end
    end
  end

  // baud generator, divides the clock down to the oversample rate
  // held at zero while idle so every frame starts on a fresh divider phase;
  // one oversample tick spans (divider + 1) clocks
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I || state_ff == ST_IDLE) begin
      bdiv_ff <= '0;
    end else if (baud_tick) begin
      bdiv_ff <= '0;
    end else begin
      bdiv_ff <= bdiv_ff + 16'h0001;
    end
  end

  // receive state machine
  // each bit lasts ovs ticks; the line is sampled once, on the tick that
  // ends at the middle of the bit, which leaves half a bit of margin for
  // the synchroniser delay and for drift between the two ends
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I || overrun_error_flag_clr) begin
      state_ff <= ST_IDLE;
      tick_ff <= '0;
      bit_ff <= '0;
      shift_ff <= '0;
      par_ff <= 1'b0;
      stop2_ff <= 1'b0;
      done_ff <= 1'b0;
      char_ff <= '0;
    end else begin
      done_ff <= 1'b0;
      if (state_ff != ST_IDLE && baud_tick) begin
        tick_ff <= bit_end ? 5'h00 : tick_ff + 5'h01;
      end
      unique case (state_ff)
        ST_IDLE: begin
          // any level away from idle starts a frame; a glitch is weeded out
          // at mid start
          tick_ff <= '0;
          if (!line) begin
            state_ff <= ST_START;
          end
        end
        ST_START: begin
          // a start that is gone by mid-bit is a glitch
          if (mid_pt && line) begin
            state_ff <= ST_IDLE;
          end else if (bit_end) begin
            state_ff <= ST_DATA;
            bit_ff <= '0;
            par_ff <= fmt == FMT_8O; // odd parity seeds one
          end
        end
        ST_DATA: begin
          // eight-bit frames shift into the low byte and keep bit 8 clear
          if (mid_pt) begin
            shift_ff <= nine ? {line, shift_ff[8:1]} : {1'b0, line, shift_ff[7:1]};
            par_ff <= par_ff ^ line;
          end
          if (bit_end) begin
            bit_ff <= bit_ff + 4'h1;
            if (bit_ff == (nine ? 4'h8 : 4'h7)) begin
              state_ff <= has_par ? ST_PAR : ST_STOP;
              stop2_ff <= mode_ff[MODE_STOP_BIT];
            end
          end
        end
        ST_PAR: begin
          if (mid_pt) begin
            char_ff.parity_error_flag <= par_ff ^ line;
          end
          if (bit_end) begin
            state_ff <= ST_STOP;
          end
        end
        ST_STOP: begin
          // every stop bit is checked; the frame ends at mid stop so the
          // receiver is back to idle in time for a following start bit
          if (mid_pt) begin
            if (!line) begin
              char_ff.framing_error_flag <= 1'b1;
            end
            if (stop2_ff) begin
              stop2_ff <= 1'b0;
            end else begin
              state_ff <= ST_IDLE;
              done_ff <= 1'b1;
              char_ff.data <= shift_ff;
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
      // flags of a new character start clear
      if (state_ff == ST_IDLE) begin
        char_ff.parity_error_flag <= 1'b0;
        char_ff.framing_error_flag <= 1'b0;
      end
    end
  end

  // address filter: with address detect on in 9-bit mode only ninth-bit-set characters are kept
  // a rejected character raises no event and leaves the buffer untouched
  wire keep = !(addren_ff && nine) || char_ff.data[8];
  wire push = done_ff && keep;
  // a full buffer or a pending overrun drops new characters
  wire store = push && !full && !overrun_error_flag_ff;
  // only pop what the setup phase actually handed out: a character that
  // lands between setup and access must stay for the next read
  wire pop = rd_data && pop_ok_ff;

  // receive buffer storage; no reset, the fill count alone says what is valid
  always_ff @(posedge CLK_I) begin
    if (store) begin
      buf_ff[wptr_ff] <= char_ff;
    end
  end

  // buffer pointers and fill count
  // an overrun clear rewinds both pointers, which empties the buffer at once
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I || overrun_error_flag_clr) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (store) begin
        wptr_ff <= wptr_ff + PW'(1);
      end
      if (pop) begin
        rptr_ff <= rptr_ff + PW'(1);
      end
      cnt_ff <= cnt_ff + (PW+1)'(store) - (PW+1)'(pop);
    end
  end

  // overrun flag; set wins over a software clear
  // a clear written in the very cycle of an overflow is lost on purpose,
  // so software never misses that a character was dropped
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      overrun_error_flag_ff <= 1'b0;
    end else if (push && full) begin
      overrun_error_flag_ff <= 1'b1;
    end else if (overrun_error_flag_clr) begin
      overrun_error_flag_ff <= 1'b0;
    end
  end

  // software-written configuration
  // writes to the status word only reach the address-detect bit; the
  // overrun clear is decoded separately above
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      mode_ff <= MODE_RST;
      baud_ff <= BAUD_RST;
      addren_ff <= 1'b0;
      irq_mask_ff <= '0;
    end else if (wr) begin
      unique case (PADDR_I)
        ADDR_MODE: mode_ff <= PWDATA_I[15:0];
        ADDR_BAUD: baud_ff <= PWDATA_I[15:0];
        ADDR_STAT: addren_ff <= PWDATA_I[STA_ADDRESS_DETECT_ENABLE_BIT];
        ADDR_IRQ_MASK: irq_mask_ff <= PWDATA_I[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // sticky events; a read clears, a same-cycle event still sets
  // the read clears only the bits that went out at setup, so an event that
  // lands between setup and access is kept for the next read
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (rd_irq ? irq_stat_ff & ~PRDATA_O[IRQ_W-1:0] : irq_stat_ff)
        | {push && full, push && (char_ff.parity_error_flag || char_ff.framing_error_flag), store};
    end
  end

  // interrupt output, registered
  // registered so the pin never glitches while status and mask settle;
  // it follows the status by one clock
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // status word
  // error flags belong to the character that the next data read returns
  logic [15:0] sta;
  always_comb begin
    sta = '0;
    sta[STA_ADDRESS_DETECT_ENABLE_BIT] = addren_ff;
    sta[STA_IDLE_BIT] = state_ff == ST_IDLE;
    sta[STA_PARITY_ERROR_FLAG_BIT] = !empty && buf_ff[rptr_ff].parity_error_flag;
    sta[STA_FRAMING_ERROR_FLAG_BIT] = !empty && buf_ff[rptr_ff].framing_error_flag;
    sta[STA_OVERRUN_ERROR_FLAG_BIT] = overrun_error_flag_ff;
    sta[STA_AVAIL_BIT] = !empty;
  end

  // apb answer: zero wait states, registered read data
  // read data is taken at setup and stands through the one access cycle
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      PRDATA_O <= '0;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      pop_ok_ff <= 1'b0;
    end else begin
      PREADY_O <= PSEL_I && !PENABLE_I;
      // remember whether this setup handed out a character to pop later
      pop_ok_ff <= PSEL_I && !PENABLE_I && PADDR_I == ADDR_DATA && !empty;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= '0;
      if (PSEL_I && !PENABLE_I) begin
        unique case (PADDR_I)
          ADDR_MODE: PRDATA_O <= {16'h0000, mode_ff};
          ADDR_STAT: PRDATA_O <= {16'h0000, sta};
          ADDR_BAUD: PRDATA_O <= {16'h0000, baud_ff};
          ADDR_DATA: PRDATA_O <= {23'h000000, empty ? 9'h000 : buf_ff[rptr_ff].data};
          ADDR_IRQ_STAT: PRDATA_O <= {29'h00000000, irq_stat_ff};
          ADDR_IRQ_MASK: PRDATA_O <= {29'h00000000, irq_mask_ff};
          default: PSLVERR_O <= 1'b1;
        endcase
      end
    end
  end
endmodule // urx_top
`default_nettype wire

// file: dv/urx_properties.sv
// assertions on the apb side of the serial receiver
`default_nettype none
module urx_properties import urx_pkg::*; (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RSTN_I,
  // apb and interrupt
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic IRQ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  // answered access, and an answered read of the status word
  wire logic ack = PSEL_I && PENABLE_I && PREADY_O;
  wire logic st_rd = ack && !PWRITE_I && PADDR_I == ADDR_STAT;
  // a write that clears overrun empties the buffer as well
  wire logic clr_wr = ack && PWRITE_I && PADDR_I == ADDR_STAT && !PWDATA_I[STA_OVERRUN_ERROR_FLAG_BIT];
  ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held too long");
  ready_answer_a: assert property (PSEL_I && !PENABLE_I |-> ##1 PREADY_O)
    else $error("no ready in access");
  unmapped_err_a: assert property (ack && !PWRITE_I && PADDR_I > ADDR_IRQ_MASK
    |-> PSLVERR_O && PRDATA_O == 32'h0)
    else $error("unmapped read answered");
  parity_error_flag_top_a: assert property (st_rd && PRDATA_O[STA_PARITY_ERROR_FLAG_BIT] |-> PRDATA_O[STA_AVAIL_BIT])
    else $error("parity flag with empty buffer");
  framing_error_flag_top_a: assert property (st_rd && PRDATA_O[STA_FRAMING_ERROR_FLAG_BIT] |-> PRDATA_O[STA_AVAIL_BIT])
    else $error("framing flag with empty buffer");
  overrun_error_flag_clear_a: assert property (clr_wr ##[1:4] st_rd |-> PRDATA_O[1:0] == 2'h0)
    else $error("buffer kept after overrun clear");
  stat_upper_a: assert property (st_rd |-> PRDATA_O[31:6] == 26'h0)
    else $error("status upper bits set");
  irq_mask_a: assert property (ack && PWRITE_I && PADDR_I == ADDR_IRQ_MASK
    && PWDATA_I[2:0] == 3'h0 |-> ##2 !IRQ_O)
    else $error("interrupt with all masked");
  cover property (st_rd && PRDATA_O[STA_OVERRUN_ERROR_FLAG_BIT]);
  cover property (st_rd && PRDATA_O[STA_FRAMING_ERROR_FLAG_BIT]);
  cover property (PSLVERR_O);
  cover property (IRQ_O);
endmodule // urx_properties
bind urx_top urx_properties i_urx_properties (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .IRQ_O(IRQ_O));
`default_nettype wire

// file: dv/urx_tx_model.sv
// remote serial transmitter driving the receive line
`default_nettype none
module urx_tx_model (
  // clock and line polarity
  input wire logic clk_i,
  input wire logic inv_i,
  // serial line
  output logic rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rx_o = 1'b1;
  // park the line at its idle level
  task automatic rest();
    rx_o <= ~inv_i;
  endtask
  // one frame lsb first; err bit0 spoils the stop, bit1 the parity
  task automatic send(input logic [8:0] d, input int nb, pm, ns, bt, input logic [1:0] err);
    logic [12:0] f;
    int n;
    f = '1;
    f[0] = 1'b0;
    for (int k = 0; k < nb; k++) f[k + 1] = d[k];
    n = nb + 1;
    if (pm != 0) begin
      f[n] = ^d[7:0] ^ (pm == 2) ^ err[1];
      n++;
    end
    f[n] = ~err[0];
    n += ns;
    for (int k = 0; k < n; k++) begin
      rx_o <= f[k] ^ inv_i;
      repeat (bt) @(posedge clk_i);
    end
    rest();
    // one idle clock so back-to-back frames never drive the line twice at once
    @(posedge clk_i);
  endtask
endmodule // urx_tx_model
`default_nettype wire

// file: dv/tb.sv
// self-checking bench for the serial receiver block
`default_nettype none
module tb;
  import urx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, inv = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rx, irq;
  int error_cnt = 0, total_checks = 0;
  always #12.5 clk = ~clk;
  // small buffer so overrun is reached fast
  urx_top #(.DEPTH(2)) i_urx_top (.CLK_I(clk), .RSTN_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .RX_I(rx), .IRQ_O(irq));
  urx_tx_model i_urx_tx_model (.clk_i(clk), .inv_i(inv), .rx_o(rx));
  // compare and count
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; result left in rd and err
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hung transfer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // empty the buffer and the interrupt status
  task automatic drain();
    repeat (3) apb(ADDR_DATA, 1'b0, 32'h0);
    apb(ADDR_IRQ_STAT, 1'b0, 32'h0);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    test_done();
  end
  initial begin
    logic [8:0] d;
    logic [1:0] fmt, bad;
    logic hs, baud, aden, keep;
    int bt, nb, pm, ns;
    void'($urandom(32'hd71d));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    apb(ADDR_MODE, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(ADDR_STAT, 1'b0, 32'h0);
    chk(rd, 32'h10);
    apb(8'h40, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("reset test done");
    // every format, stop count and polarity, random data and faults
    for (int i = 0; i < 16; i++) begin
      fmt = i[1:0];
      ns = i[2] ? 2 : 1;
      inv <= i[3];
      hs = 1'($urandom_range(0, 1));
      baud = 1'($urandom_range(0, 1));
      bad = 2'($urandom_range(0, 3));
      d = 9'($urandom_range(0, 511));
      aden = (fmt == FMT_9N);
      if (aden) d[8] = i[2];
      bt = (baud + 1) * (hs ? 4 : 16);
      nb = aden ? 9 : 8;
      pm = (fmt == FMT_8O) ? 2 : int'(fmt == FMT_8E);
      apb(ADDR_MODE, 1'b1, {27'h0, i[3], hs, fmt, i[2]});
      apb(ADDR_BAUD, 1'b1, {31'h0, baud});
      apb(ADDR_STAT, 1'b1, {26'h0, aden, 5'h02});
      i_urx_tx_model.rest();
      repeat (600) @(posedge clk);
      drain();
      i_urx_tx_model.send(d, nb, pm, ns, bt, bad);
      // a spoilt stop may start a false frame; let it die at mid start
      repeat (bt + 8) @(posedge clk);
      keep = !(aden && !d[8]);
      apb(ADDR_STAT, 1'b0, 32'h0);
      chk(rd, {26'h0, aden, 1'b1, keep && bad[1] && pm != 0, keep && bad[0], 1'b0, keep});
      apb(ADDR_DATA, 1'b0, 32'h0);
      chk(rd, keep ? {23'h0, aden ? d : {1'b0, d[7:0]}} : 32'h0);
      apb(ADDR_IRQ_STAT, 1'b0, 32'h0);
      chk(rd, {29'h0, 1'b0, keep && (bad[0] || (bad[1] && pm != 0)), keep});
    end
    $display("frame test done");
    // overflow a two-deep buffer with interrupts unmasked
    apb(ADDR_STAT, 1'b1, 32'h2);
    apb(ADDR_IRQ_MASK, 1'b1, 32'h7);
    drain();
    repeat (3) i_urx_tx_model.send(9'h1A5, 9, 0, 2, bt, 2'h0);
    repeat (8) @(posedge clk);
    apb(ADDR_STAT, 1'b0, 32'h0);
    chk(rd, 32'h13);
    chk({31'h0, irq}, 32'h1);
    apb(ADDR_IRQ_STAT, 1'b0, 32'h0);
    chk(rd, 32'h5);
    apb(ADDR_IRQ_STAT, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(ADDR_STAT, 1'b1, 32'h0);
    apb(ADDR_STAT, 1'b0, 32'h0);
    chk(rd, 32'h10);
    chk({31'h0, irq}, 32'h0);
    // masked event; status read while the frame is on the line
    apb(ADDR_IRQ_MASK, 1'b1, 32'h0);
    fork
      i_urx_tx_model.send(9'h0C3, 9, 0, 2, bt, 2'h0);
      begin
        repeat (3 * bt) @(posedge clk);
        apb(ADDR_STAT, 1'b0, 32'h0);
        chk({31'h0, rd[STA_IDLE_BIT]}, 32'h0);
      end
    join
    repeat (8) @(posedge clk);
    apb(ADDR_STAT, 1'b0, 32'h0);
    chk(rd, 32'h11);
    chk({31'h0, irq}, 32'h0);
    apb(ADDR_IRQ_STAT, 1'b0, 32'h0);
    chk(rd, 32'h1);
    $display("overrun test done");
    test_done();
  end
endmodule // tb
`default_nettype wire
